// ===== shared/vpia_pkg.sv
/*
 * Constants, register map and state type of the vectored priority interrupt arbiter.
 * Assumes a 16-bit register port on the system clock and a core on the same clock
 * that presents its current priority mask.
 */
// Contract
// - Each of sources 9 to 65 has a field that gives it level 0, 1 or 2 or disables it.
// - Within one level the lowest active vector number wins.
// - With a pending request of enough priority the core gets a request and a service address.
// - There are two fast slots, each of which may name any one source.
// - The winning vector number is compared against both slot match registers.
// - A request is fast only on a slot match at level 2; any other match is normal.
// - A fast request gets the slot address instead of the vector base offset.
// - Fast requests are identified here, so the fast address is ready with the request.
// - The vector base resets to 0x0020, placing the table at word address 0x002000.
// - Chip reset uses vector 0 and watchdog reset vector 1 of the table.
// - Programmable levels are 0, 1 and 2, with a fixed level 3 above them.
// - Illegal instruction, stack overflow, misaligned access and level-3 software sit at 3 unmasked.
// - Debug step counter, breakpoint and trace requests sit at level 3 but can be masked.
package vpia_pkg;
    // ****************
    // sizes
    // ****************
    localparam int NUM_SRC = 66;
    localparam int VEC_W = 7;
    localparam int ADDR_W = 24;
    localparam int DATA_W = 16;
    localparam int REG_AW = 5;
    localparam int PRIO_REGS = 9;
    localparam int FIELDS_PER_REG = 8;
    localparam int FIELD_W = 2;
    localparam int NUM_SLOTS = 2;
    localparam int NUM_LVL = 4;
    localparam int HIGH_W = 8;

    // ****************
    // levels and vectors
    // ****************
    localparam logic [1:0] FIELD_OFF = 2'h0;
    localparam logic [1:0] LVL_FAST = 2'h2;
    localparam logic [1:0] LVL_TOP = 2'h3;
    localparam int VEC_CHIP_RST = 0;
    localparam int VEC_WDOG_RST = 1;
    localparam int VEC_UNMASK_LO = 2;
    localparam int VEC_UNMASK_HI = 5;
    localparam int VEC_MASK_LO = 6;
    localparam int VEC_MASK_HI = 8;
    localparam int TABLE_SHIFT = 8;
    localparam logic [ADDR_W-1:0] WDOG_ENTRY = 24'h000002;

    // ****************
    // register map, word offsets
    // ****************
    localparam logic [REG_AW-1:0] OFF_PRIO_LAST = 5'h08;
    localparam logic [REG_AW-1:0] OFF_VBASE = 5'h09;
    localparam logic [REG_AW-1:0] OFF_FMATCH0 = 5'h0A;
    localparam logic [REG_AW-1:0] OFF_FMATCH1 = 5'h0B;
    localparam logic [REG_AW-1:0] OFF_FLOW0 = 5'h0C;
    localparam logic [REG_AW-1:0] OFF_FHIGH0 = 5'h0D;
    localparam logic [REG_AW-1:0] OFF_FLOW1 = 5'h0E;
    localparam logic [REG_AW-1:0] OFF_FHIGH1 = 5'h0F;
    localparam logic [REG_AW-1:0] OFF_STATUS = 5'h10;
    localparam logic [DATA_W-1:0] VBASE_RST = 16'h0020;
    localparam int ST_IRQ = 15;
    localparam int ST_FAST = 14;
    localparam int ST_LVL = 12;

    typedef struct packed {
        logic [PRIO_REGS-1:0][DATA_W-1:0] prio;
        logic [DATA_W-1:0] vbase;
        logic [NUM_SLOTS-1:0][VEC_W-1:0] fmatch;
        logic [NUM_SLOTS-1:0][DATA_W-1:0] flow;
        logic [NUM_SLOTS-1:0][HIGH_W-1:0] fhigh;
        logic [DATA_W-1:0] rdata;
        logic irq;
        logic fast;
        logic [1:0] lvl;
        logic [VEC_W-1:0] vnum;
        logic [ADDR_W-1:0] vaddr;
        logic [ADDR_W-1:0] raddr;
    } vpia_state_type;
endpackage

// ===== verilog/vpia_first_set.sv
/*
 * Lowest-index finder for one priority level of the arbiter.
 * Purely combinational; the caller registers the result.
 */
`timescale 1ns/1ps
module vpia_first_set #(
    parameter int N = 66,
    parameter int IW = 7
) (
    // requests of one level
    input logic [N-1:0] req,
    // lowest set request
    output logic found,
    output logic [IW-1:0] index
);
    if (N < 1 || N > (1 << IW)) begin : g_bad_size
        $error("vpia_first_set: N does not fit the index width");
    end

    // scanning downward lets the lowest set bit overwrite all others
    always_comb begin
        found = 1'b0;
        index = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (req[i]) begin
                found = 1'b1;
                index = IW'(i);
            end
        end
    end
endmodule

// ===== verilog/vpia_arbiter.sv
/*
 * Vectored priority interrupt arbiter: per-source level fields, level and
 * vector arbitration, two fast slots, vector base and reset addresses.
 * Assumes requests, core mask and watchdog flag come from logic on sys_clk,
 * and a register master that never issues read and write together.
 */
`timescale 1ns/1ps
module vpia_arbiter #(
    parameter int NUM_SRC = vpia_pkg::NUM_SRC
) (
    // clock and reset
    input logic sys_clk,
    input logic sys_rst,
    // peripheral requests, one level per source
    input logic [NUM_SRC-1:0] irq_src,
    // register port
    input logic [vpia_pkg::REG_AW-1:0] reg_addr,
    input logic [vpia_pkg::DATA_W-1:0] reg_wdata,
    input logic reg_wr,
    input logic reg_rd,
    output logic [vpia_pkg::DATA_W-1:0] reg_rdata,
    // core side
    input logic [1:0] core_mask,
    input logic wdog_reset_seen,
    output logic core_irq,
    output logic core_fast,
    output logic [1:0] core_level,
    output logic [vpia_pkg::VEC_W-1:0] core_vec_num,
    output logic [vpia_pkg::ADDR_W-1:0] core_vec_addr,
    output logic [vpia_pkg::ADDR_W-1:0] core_reset_addr
);
    import vpia_pkg::*;

    if (NUM_SRC <= VEC_MASK_HI || NUM_SRC > PRIO_REGS * FIELDS_PER_REG
        || NUM_SRC > (1 << VEC_W)) begin : g_bad_src
        $error("vpia_arbiter: NUM_SRC out of range");
    end

    // ****************
    // source level decode
    // ****************
    // returns {enabled, level}
    function automatic logic [2:0] src_tier(
        input logic [PRIO_REGS-1:0][DATA_W-1:0] prio,
        input int v
    );
        logic [FIELD_W-1:0] field;
        field = prio[v / FIELDS_PER_REG][(v % FIELDS_PER_REG) * FIELD_W +: FIELD_W];
        if (v == VEC_CHIP_RST || v == VEC_WDOG_RST) begin
            // reset vectors are never arbitrated
            return 3'h0;
        end else if (v >= VEC_UNMASK_LO && v <= VEC_UNMASK_HI) begin
            return {1'b1, LVL_TOP};
        end else if (v >= VEC_MASK_LO && v <= VEC_MASK_HI) begin
            // field only masks, level stays fixed
            return {field != FIELD_OFF, LVL_TOP};
        end else begin
            // code 0 disables, codes 1..3 give levels 0..2
            return {field != FIELD_OFF, 2'(field - 2'h1)};
        end
    endfunction

    vpia_state_type state_ff;
    vpia_state_type nxt_state;

    logic [NUM_SRC-1:0][2:0] tier;
    logic [NUM_LVL-1:0][NUM_SRC-1:0] lvl_req;
    logic [NUM_LVL-1:0] lvl_found;
    logic [NUM_LVL-1:0][VEC_W-1:0] lvl_idx;

    for (genvar g = 0; g < NUM_SRC; g++) begin : g_src
        assign tier[g] = src_tier(state_ff.prio, g);
        for (genvar l = 0; l < NUM_LVL; l++) begin : g_lvl
            assign lvl_req[l][g] = irq_src[g] & tier[g][2] & (tier[g][1:0] == 2'(l));
        end
    end

    // ****************
    // per-level encoders
    // ****************
    for (genvar l = 0; l < NUM_LVL; l++) begin : g_enc
        vpia_first_set #(
            .N(NUM_SRC),
            .IW(VEC_W)
        ) u_first (
            .req(lvl_req[l]),
            .found(lvl_found[l]),
            .index(lvl_idx[l])
        );
    end

    // ****************
    // winner, mask and fast slots
    // ****************
    logic win_found;
    logic [1:0] win_lvl;
    logic [VEC_W-1:0] win_num;
    logic fwd;
    logic fast_hit;
    logic [ADDR_W-1:0] fast_addr;
    logic [ADDR_W-1:0] table_base;

    always_comb begin
        win_found = 1'b0;
        win_lvl = 2'h0;
        win_num = '0;
        // later, higher levels overwrite lower ones
        for (int l = 0; l < NUM_LVL; l++) begin
            if (lvl_found[l]) begin
                win_found = 1'b1;
                win_lvl = 2'(l);
                win_num = lvl_idx[l];
            end
        end
    end

    assign fwd = win_found && (win_lvl == LVL_TOP || win_lvl >= core_mask);

    // slot 0 wins if both slots name the same vector
    always_comb begin
        fast_hit = 1'b0;
        fast_addr = '0;
        for (int s = NUM_SLOTS - 1; s >= 0; s--) begin
            if (win_lvl == LVL_FAST && win_num == state_ff.fmatch[s]) begin
                fast_hit = 1'b1;
                fast_addr = {state_ff.fhigh[s], state_ff.flow[s]};
            end
        end
    end

    assign table_base = {state_ff.vbase, 8'h00};

    // ****************
    // next state
    // ****************
    always_comb begin
        nxt_state = state_ff;
        // read data stand for one cycle only
        nxt_state.rdata = '0;
        // no byte lanes: every write replaces the whole word
        if (reg_wr) begin
            if (reg_addr <= OFF_PRIO_LAST) begin
                nxt_state.prio[reg_addr[3:0]] = reg_wdata;
            end
            case (reg_addr)
                OFF_VBASE: nxt_state.vbase = reg_wdata;
                OFF_FMATCH0: nxt_state.fmatch[0] = reg_wdata[VEC_W-1:0];
                OFF_FMATCH1: nxt_state.fmatch[1] = reg_wdata[VEC_W-1:0];
                OFF_FLOW0: nxt_state.flow[0] = reg_wdata;
                OFF_FHIGH0: nxt_state.fhigh[0] = reg_wdata[HIGH_W-1:0];
                OFF_FLOW1: nxt_state.flow[1] = reg_wdata;
                OFF_FHIGH1: nxt_state.fhigh[1] = reg_wdata[HIGH_W-1:0];
                default: ;
            endcase
        end
        if (reg_rd) begin
            if (reg_addr <= OFF_PRIO_LAST) begin
                nxt_state.rdata = state_ff.prio[reg_addr[3:0]];
            end
            case (reg_addr)
                OFF_VBASE: nxt_state.rdata = state_ff.vbase;
                OFF_FMATCH0: nxt_state.rdata = DATA_W'(state_ff.fmatch[0]);
                OFF_FMATCH1: nxt_state.rdata = DATA_W'(state_ff.fmatch[1]);
                OFF_FLOW0: nxt_state.rdata = state_ff.flow[0];
                OFF_FHIGH0: nxt_state.rdata = DATA_W'(state_ff.fhigh[0]);
                OFF_FLOW1: nxt_state.rdata = state_ff.flow[1];
                OFF_FHIGH1: nxt_state.rdata = DATA_W'(state_ff.fhigh[1]);
                OFF_STATUS: begin
                    nxt_state.rdata[ST_IRQ] = state_ff.irq;
                    nxt_state.rdata[ST_FAST] = state_ff.fast;
                    nxt_state.rdata[ST_LVL +: 2] = state_ff.lvl;
                    nxt_state.rdata[VEC_W-1:0] = state_ff.vnum;
                end
                default: ;
            endcase
        end
        // core request and address leave in the same register stage,
        // so a fast address never trails its request
        nxt_state.irq = fwd;
        nxt_state.fast = fwd & fast_hit;
        nxt_state.lvl = win_lvl;
        nxt_state.vnum = win_num;
        nxt_state.vaddr = fast_hit ? fast_addr
            : table_base + ADDR_W'({win_num, 1'b0});
        nxt_state.raddr = table_base + (wdog_reset_seen ? WDOG_ENTRY : '0);
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_ff <= '0;
            state_ff.vbase <= VBASE_RST;
            state_ff.raddr <= {VBASE_RST, 8'h00};
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign reg_rdata = state_ff.rdata;
    assign core_irq = state_ff.irq;
    assign core_fast = state_ff.fast;
    assign core_level = state_ff.lvl;
    assign core_vec_num = state_ff.vnum;
    assign core_vec_addr = state_ff.vaddr;
    assign core_reset_addr = state_ff.raddr;

    // ****************
    // checks
    // ****************
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    // true when v is the lowest active request of level l in the inputs of
    // the cycle before; built from the fields, not from the encoders
    function automatic logic lowest_of_level(
        input logic [NUM_SRC-1:0] src,
        input logic [PRIO_REGS-1:0][DATA_W-1:0] prio,
        input logic [1:0] l,
        input logic [VEC_W-1:0] v
    );
        logic seen;
        logic ok;
        seen = 1'b0;
        ok = 1'b0;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (!seen && src[i] && src_tier(prio, i) == {1'b1, l}) begin
                seen = 1'b1;
                ok = (VEC_W'(i) == v);
            end
        end
        return ok;
    endfunction

    vbase_reset_a: assert property ($fell(sys_rst) |-> state_ff.vbase == VBASE_RST)
        else $error("vector base not at reset value after reset");
    unmask_top_a: assert property (|irq_src[VEC_UNMASK_HI:VEC_UNMASK_LO]
        |=> core_irq && core_level == LVL_TOP)
        else $error("unmaskable source not forwarded at top level");
    lowest_wins_a: assert property (core_irq |-> lowest_of_level($past(irq_src),
        $past(state_ff.prio), core_level, core_vec_num))
        else $error("winner is not the lowest active vector of its level");
    top_level_a: assert property (core_irq |-> ($past(lvl_found) >> core_level) == 4'h1)
        else $error("a higher level was pending");
    mask_gate_a: assert property (core_irq |-> core_level == LVL_TOP
        || core_level >= $past(core_mask))
        else $error("request forwarded below core mask");
    top_forward_a: assert property (|lvl_req[LVL_TOP]
        |=> core_irq && core_level == LVL_TOP)
        else $error("level 3 request not forwarded");
    no_source_a: assert property (irq_src == '0 |=> !core_irq)
        else $error("request forwarded with no source active");
    fast_level_a: assert property (core_fast |-> core_irq && core_level == LVL_FAST)
        else $error("fast request not at level 2");
    fast_match_a: assert property (core_irq && core_level == LVL_FAST
        && (core_vec_num == $past(state_ff.fmatch[0])
        || core_vec_num == $past(state_ff.fmatch[1])) |-> core_fast)
        else $error("slot match at level 2 not taken as fast");
    fast_slot_a: assert property (core_fast |-> core_vec_num == $past(state_ff.fmatch[0])
        || core_vec_num == $past(state_ff.fmatch[1]))
        else $error("fast request names no slot");
    fast_addr_a: assert property (core_fast && core_vec_num == $past(state_ff.fmatch[0])
        |-> core_vec_addr == {$past(state_ff.fhigh[0]), $past(state_ff.flow[0])})
        else $error("fast address not from slot 0");
    fast_addr1_a: assert property (core_fast && core_vec_num != $past(state_ff.fmatch[0])
        |-> core_vec_addr == {$past(state_ff.fhigh[1]), $past(state_ff.flow[1])})
        else $error("fast address not from slot 1");
    normal_addr_a: assert property (core_irq && !core_fast |-> core_vec_addr
        == {$past(state_ff.vbase), 8'h00} + ADDR_W'({core_vec_num, 1'b0}))
        else $error("normal address not offset from vector base");
    reset_addr_a: assert property (##1 core_reset_addr == {$past(state_ff.vbase), 8'h00}
        + ($past(wdog_reset_seen) ? WDOG_ENTRY : '0))
        else $error("reset address wrong");
    read_base_a: assert property (reg_rd && reg_addr == OFF_VBASE
        |=> reg_rdata == $past(state_ff.vbase) ##1 reg_rdata == '0 || $past(reg_rd))
        else $error("vector base read data wrong");
    read_prio_a: assert property (reg_rd && reg_addr <= OFF_PRIO_LAST
        |=> reg_rdata == $past(state_ff.prio[reg_addr[3:0]]))
        else $error("priority field read data wrong");
    read_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == '0)
        else $error("read data not cleared after the read cycle");
    read_unmapped_a: assert property (reg_rd && reg_addr > OFF_STATUS |=> reg_rdata == '0)
        else $error("unmapped offset read back nonzero");

    fast_taken_c: cover property ($rose(core_irq) && core_fast);
    normal_taken_c: cover property ($rose(core_irq) && !core_fast);
    top_level_c: cover property (core_irq && core_level == LVL_TOP);
    masked_hold_c: cover property ($past(win_found) && !core_irq);
    fast_slot1_c: cover property (core_fast && core_vec_num == state_ff.fmatch[1]);
endmodule

// ===== tb/vpia_core_model.sv
/*
 * Behavioural core as seen by the arbiter: presents a priority mask and the
 * watchdog-reset flag, and latches the service address at a request.
 * Assumes the same sys_clk and sys_rst as the arbiter.
 */
`timescale 1ns/1ps
module vpia_core_model
    import vpia_pkg::*;
(
    // clock and reset
    input logic sys_clk,
    input logic sys_rst,
    // bench controls
    input logic [1:0] mask_req,
    input logic wdog_req,
    // arbiter side
    input logic core_irq,
    input logic [ADDR_W-1:0] core_vec_addr,
    output logic [1:0] core_mask,
    output logic wdog_reset_seen,
    output logic [ADDR_W-1:0] fetch_addr
);
    // ****************
    // mask and fetch
    // ****************
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            core_mask <= 2'h0;
            wdog_reset_seen <= 1'b0;
            fetch_addr <= 24'h000000;
        end else begin
            core_mask <= mask_req;
            wdog_reset_seen <= wdog_req;
            // no recognition stage: the address must already be right
            if (core_irq) begin
                fetch_addr <= core_vec_addr;
            end
        end
    end
endmodule

// ===== tb/vpia_arbiter_tb.sv
/*
 * Self-checking bench for the interrupt arbiter: register port tasks,
 * arbitration, masking, fast slots and reset addresses.
 * Assumes the core model in vpia_core_model.sv and the default 66 sources.
 */
`timescale 1ns/1ps
module vpia_arbiter_tb;
    import vpia_pkg::*;
    logic sys_clk;
    logic sys_rst;
    logic [NUM_SRC-1:0] irq_src;
    logic [REG_AW-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [DATA_W-1:0] reg_rdata;
    logic [1:0] core_mask;
    logic wdog_reset_seen;
    logic core_irq;
    logic core_fast;
    logic [1:0] core_level;
    logic [VEC_W-1:0] core_vec_num;
    logic [ADDR_W-1:0] core_vec_addr;
    logic [ADDR_W-1:0] core_reset_addr;
    logic [1:0] mask_req;
    logic wdog_req;
    logic [ADDR_W-1:0] fetch_addr;
    logic [DATA_W-1:0] psh [PRIO_REGS];
    int err_count;
    int comparisons;

    vpia_arbiter DUT (.sys_clk(sys_clk), .sys_rst(sys_rst), .irq_src(irq_src),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .core_mask(core_mask), .wdog_reset_seen(wdog_reset_seen),
        .core_irq(core_irq), .core_fast(core_fast), .core_level(core_level),
        .core_vec_num(core_vec_num), .core_vec_addr(core_vec_addr),
        .core_reset_addr(core_reset_addr));

    vpia_core_model core (.sys_clk(sys_clk), .sys_rst(sys_rst), .mask_req(mask_req),
        .wdog_req(wdog_req), .core_irq(core_irq), .core_vec_addr(core_vec_addr),
        .core_mask(core_mask), .wdog_reset_seen(wdog_reset_seen), .fetch_addr(fetch_addr));

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    // ****************
    // helpers
    // ****************
    task automatic finish_test();
        $display("errors %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [ADDR_W-1:0] got, input logic [ADDR_W-1:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [REG_AW-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [REG_AW-1:0] a, input logic [DATA_W-1:0] e);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, e);
    endtask

    task automatic lvl(input int v, input logic [1:0] code);
        psh[v / FIELDS_PER_REG][FIELD_W * (v % FIELDS_PER_REG) +: FIELD_W] = code;
        wr(REG_AW'(v / FIELDS_PER_REG), psh[v / FIELDS_PER_REG]);
    endtask

    // core model stage, arbiter stage, one spare edge
    task automatic settle();
        repeat (3) @(posedge sys_clk);
        #1;
    endtask

    task automatic expect_out(input logic i, input logic f, input logic [1:0] l,
        input logic [VEC_W-1:0] v, input logic [ADDR_W-1:0] a);
        settle();
        chk(core_irq, i);
        chk(core_fast, f);
        chk(core_level, l);
        chk(core_vec_num, v);
        chk(core_vec_addr, a);
    endtask

    // ****************
    // scenarios
    // ****************
    initial begin
        sys_rst = 1'b1;
        irq_src = '0;
        reg_addr = '0;
        reg_wdata = '0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        mask_req = 2'h0;
        wdog_req = 1'b0;
        err_count = 0;
        comparisons = 0;
        for (int i = 0; i < PRIO_REGS; i++) begin
            psh[i] = 16'h0000;
        end
        repeat (5) @(posedge sys_clk);
        sys_rst <= 1'b0;
        rd(OFF_VBASE, 16'h0020);
        chk(core_reset_addr, 24'h002000);
        rd(5'h11, 16'h0000);
        rd(OFF_STATUS, 16'h0000);
        @(posedge sys_clk) wdog_req <= 1'b1;
        settle();
        chk(core_reset_addr, 24'h002002);
        @(posedge sys_clk);
        wdog_req <= 1'b0;
        irq_src[20] <= 1'b1;
        irq_src[12] <= 1'b1;
        settle();
        chk(core_irq, 1'b0);
        lvl(20, 2'h2);
        lvl(12, 2'h2);
        rd(5'h02, 16'h0200);
        expect_out(1'b1, 1'b0, 2'h1, 7'h0C, 24'h002018);
        lvl(12, 2'h0);
        expect_out(1'b1, 1'b0, 2'h1, 7'h14, 24'h002028);
        lvl(40, 2'h3);
        @(posedge sys_clk) irq_src[40] <= 1'b1;
        expect_out(1'b1, 1'b0, 2'h2, 7'h28, 24'h002050);
        @(posedge sys_clk) mask_req <= 2'h3;
        settle();
        chk(core_irq, 1'b0);
        @(posedge sys_clk) irq_src[3] <= 1'b1;
        expect_out(1'b1, 1'b0, 2'h3, 7'h03, 24'h002006);
        @(posedge sys_clk);
        irq_src[3] <= 1'b0;
        irq_src[7] <= 1'b1;
        settle();
        chk(core_irq, 1'b0);
        lvl(7, 2'h1);
        expect_out(1'b1, 1'b0, 2'h3, 7'h07, 24'h00200E);
        @(posedge sys_clk);
        irq_src[7] <= 1'b0;
        irq_src[20] <= 1'b0;
        irq_src[40] <= 1'b0;
        mask_req <= 2'h0;
        wr(OFF_FMATCH0, 16'hFF8A);
        wr(OFF_FLOW0, 16'h1234);
        wr(OFF_FHIGH0, 16'hFF56);
        rd(OFF_FHIGH0, 16'h0056);
        rd(OFF_FMATCH0, 16'h000A);
        wr(OFF_FMATCH1, 16'h001E);
        wr(OFF_FLOW1, 16'hBEEF);
        wr(OFF_FHIGH1, 16'h0077);
        rd(OFF_FMATCH1, 16'h001E);
        rd(OFF_FLOW1, 16'hBEEF);
        lvl(10, 2'h3);
        @(posedge sys_clk) irq_src[10] <= 1'b1;
        expect_out(1'b1, 1'b1, 2'h2, 7'h0A, 24'h561234);
        chk(fetch_addr, 24'h561234);
        rd(OFF_STATUS, 16'hE00A);
        @(posedge sys_clk) irq_src[10] <= 1'b0;
        lvl(30, 2'h3);
        @(posedge sys_clk) irq_src[30] <= 1'b1;
        expect_out(1'b1, 1'b1, 2'h2, 7'h1E, 24'h77BEEF);
        lvl(30, 2'h2);
        expect_out(1'b1, 1'b0, 2'h1, 7'h1E, 24'h00203C);
        wr(OFF_VBASE, 16'h0041);
        expect_out(1'b1, 1'b0, 2'h1, 7'h1E, 24'h00413C);
        chk(core_reset_addr, 24'h004100);
        @(posedge sys_clk) sys_rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        rd(OFF_VBASE, 16'h0020);
        chk(core_reset_addr, 24'h002000);
        chk(core_irq, 1'b0);
        finish_test();
    end

    // cuts a hang short
    initial begin
        #2000000;
        err_count++;
        finish_test();
    end
endmodule
